// ### qsp_consts.svh
// Purpose: Shared constants for the burst SRAM port and its controller
// Assumes: Included by bare name wherever a figure is needed
// Notes: Bus widths cover the widest organisation
`ifndef QSP_CONSTS_SVH
`define QSP_CONSTS_SVH

// Link bus widths
`define QSP_DW 36
`define QSP_AW 21
`define QSP_LANES 4

// Address widths per organisation
`define QSP_AW_X8 21
`define QSP_AW_X9 21
`define QSP_AW_X18 20
`define QSP_AW_X36 19

// Lane widths
`define QSP_NIB_W 4
`define QSP_BYTE_W 9

// Organisation codes
`define QSP_VAR_X8 2'h0
`define QSP_VAR_X9 2'h1
`define QSP_VAR_X18 2'h2
`define QSP_VAR_X36 2'h3

// Burst word positions
`define QSP_WORD0 1'b0
`define QSP_WORD1 1'b1

// Idle levels
`define QSP_SEL_IDLE 1'b1
`define QSP_LANES_OFF 4'h0
`define QSP_DATA_ZERO 36'h0_0000_0000
`define QSP_ADDR_ZERO 21'h00_0000
`define QSP_MASK_NONE 36'h0_0000_0000

`endif

// ### qsp_pkg.sv
// Purpose: Types for the burst SRAM port and its controller
// Assumes: Constants come from qsp_consts.svh
// Notes: Each end keeps its state in one struct, except the port's array
`include "qsp_consts.svh"

package qsp_pkg;

  typedef logic [`QSP_DW-1:0] qsp_data_t;
  typedef logic [`QSP_AW-1:0] qsp_addr_t;
  typedef logic [`QSP_LANES-1:0] qsp_lane_t;

  typedef enum logic [1:0] {
    QSP_RD_IDLE,
    QSP_RD_WORD0,
    QSP_RD_WORD1
  } qsp_rd_e;

  typedef struct packed {
    logic wr_act;
    qsp_data_t wr_w0;
    qsp_data_t wr_m0;
    logic rd_pend;
    qsp_addr_t rd_pend_addr;
    qsp_addr_t rd_addr;
    qsp_rd_e rd_st;
    qsp_data_t q;
    logic q_oe;
  } qsp_dev_s;

  typedef struct packed {
    logic lclk;
    logic kph;
    logic single;
    logic rd_sel_n;
    logic wr_sel_n;
    qsp_addr_t addr;
    qsp_data_t d;
    qsp_lane_t lanes_n;
    logic rd_pend;
    qsp_addr_t rd_pa;
    logic wr_pend;
    logic wr_stage;
    qsp_addr_t wr_pa;
    qsp_data_t wd0;
    qsp_data_t wd1;
    qsp_lane_t wl0_n;
    qsp_lane_t wl1_n;
    qsp_data_t q_s1;
    qsp_data_t q_s2;
    logic oe_s1;
    logic oe_s2;
    logic widx;
    qsp_data_t rd_data;
    logic rd_valid;
    logic rd_word;
    logic rd_ready;
    logic wr_ready;
  } qsp_ctl_s;

endpackage : qsp_pkg

// ### qsp_link_if.sv
// Purpose: Pin-level link between the SRAM port and its controller
// Assumes: Every rising link_clk edge is one input clock edge; k_phase tells which
// Notes: q and q_oe stay apart; whoever watches the pins resolves the bus
`timescale 1ns/10ps
`include "qsp_consts.svh"

interface qsp_link_if;
  import qsp_pkg::*;

  // Clocks: rising link_clk with k_phase high is the positive input clock
  logic link_clk;
  logic k_phase;
  logic c_phase;
  logic single_clk_mode;
  // Port selects and shared address
  logic rd_port_sel_n;
  logic wr_port_sel_n;
  qsp_addr_t addr;
  // Write data and lane enables (nibble_lane_enX_n or byte_lane_enX_n)
  qsp_data_t d;
  qsp_lane_t lane_en_n;
  // Read data
  qsp_data_t q;
  logic q_oe;

  modport dev (
    input link_clk, k_phase, c_phase, single_clk_mode,
    input rd_port_sel_n, wr_port_sel_n, addr, d, lane_en_n,
    output q, q_oe
  );

  modport ctl (
    output link_clk, k_phase, c_phase, single_clk_mode,
    output rd_port_sel_n, wr_port_sel_n, addr, d, lane_en_n,
    input q, q_oe
  );

endinterface : qsp_link_if

// ### qsp_sram_dev.sv
// Purpose: Separate-I/O two-word burst SRAM port logic with its array
// Assumes: i_nrst is synchronous to the link clock; inputs are source-synchronous
// Notes: Organisation chosen by VARIANT; the array is sized to match
`timescale 1ns/10ps
`include "qsp_consts.svh"

module qsp_sram_dev
  import qsp_pkg::*;
#(
  parameter logic [1:0] VARIANT = `QSP_VAR_X36
) (
  // Link
  qsp_link_if.dev link,
  // Control
  input wire logic i_nrst,
  input wire logic i_ce
);

  localparam int ADDR_W = (VARIANT == `QSP_VAR_X36) ? `QSP_AW_X36 :
                          (VARIANT == `QSP_VAR_X18) ? `QSP_AW_X18 :
                          (VARIANT == `QSP_VAR_X9) ? `QSP_AW_X9 : `QSP_AW_X8;
  localparam int DEPTH = 1 << (ADDR_W + 1);

  qsp_dev_s s;
  qsp_dev_s next_s;
  qsp_data_t mem [0:DEPTH-1];
  logic wr_go;
  logic [ADDR_W:0] wr_idx0;
  logic [ADDR_W:0] wr_idx1;
  qsp_data_t wr_m1;
  logic launch;
  qsp_data_t word0;
  qsp_data_t word1;

  // Unused lanes give a zero mask so untouched bits never change
  function automatic qsp_data_t lane_mask(input qsp_lane_t en_n);
    qsp_data_t m;
    m = `QSP_MASK_NONE;
    case (VARIANT)
      `QSP_VAR_X8: begin
        m[`QSP_NIB_W-1:0] = {`QSP_NIB_W{~en_n[0]}};
        m[2*`QSP_NIB_W-1:`QSP_NIB_W] = {`QSP_NIB_W{~en_n[1]}};
      end
      `QSP_VAR_X9: begin
        m[`QSP_BYTE_W-1:0] = {`QSP_BYTE_W{~en_n[0]}};
      end
      `QSP_VAR_X18: begin
        m[`QSP_BYTE_W-1:0] = {`QSP_BYTE_W{~en_n[0]}};
        m[2*`QSP_BYTE_W-1:`QSP_BYTE_W] = {`QSP_BYTE_W{~en_n[1]}};
      end
      default: begin
        for (int i = 0; i < `QSP_LANES; i++) begin
          m[i*`QSP_BYTE_W +: `QSP_BYTE_W] = {`QSP_BYTE_W{~en_n[i]}};
        end
      end
    endcase
    return m;
  endfunction : lane_mask

  // Drop address bits above the organisation's width
  function automatic qsp_addr_t addr_trim(input qsp_addr_t a);
    qsp_addr_t t;
    t = `QSP_ADDR_ZERO;
    t[ADDR_W-1:0] = a[ADDR_W-1:0];
    return t;
  endfunction : addr_trim

  // Single-clock mode launches on input clock edges instead
  assign launch = link.single_clk_mode ? link.k_phase : link.c_phase;

  assign wr_go = i_ce && i_nrst && s.wr_act && !link.k_phase;
  assign wr_idx0 = {link.addr[ADDR_W-1:0], `QSP_WORD0};
  assign wr_idx1 = {link.addr[ADDR_W-1:0], `QSP_WORD1};
  assign wr_m1 = lane_mask(link.lane_en_n);
  assign word0 = mem[{s.rd_pend_addr[ADDR_W-1:0], `QSP_WORD0}];
  assign word1 = mem[{s.rd_addr[ADDR_W-1:0], `QSP_WORD1}];

  always_comb begin
    next_s = s;
    if (link.k_phase) begin
      // Positive input clock: all accesses begin here
      next_s.wr_act = !link.wr_port_sel_n;
      if (!link.wr_port_sel_n) begin
        next_s.wr_w0 = link.d;
        next_s.wr_m0 = lane_mask(link.lane_en_n);
      end
    end else begin
      // Write address is taken at K# only for a live write
      next_s.wr_act = 1'b0;
    end
    if (launch) begin
      if (s.rd_pend) begin
        next_s.q = word0;
        next_s.q_oe = 1'b1;
        next_s.rd_addr = s.rd_pend_addr;
        next_s.rd_pend = 1'b0;
        next_s.rd_st = QSP_RD_WORD0;
      end else begin
        next_s.q_oe = 1'b0;
        next_s.rd_st = QSP_RD_IDLE;
      end
    end else begin
      case (s.rd_st)
        QSP_RD_WORD0: begin
          next_s.q = word1;
          next_s.rd_st = QSP_RD_WORD1;
        end
        QSP_RD_WORD1: begin
          next_s.rd_st = QSP_RD_WORD1;
        end
        QSP_RD_IDLE: begin
          next_s.rd_st = QSP_RD_IDLE;
        end
        default: begin
          next_s.rd_st = QSP_RD_IDLE;
        end
      endcase
    end
    // Taken after the launch so a new request outlives the clear
    if (link.k_phase && !link.rd_port_sel_n) begin
      next_s.rd_pend = 1'b1;
      next_s.rd_pend_addr = addr_trim(link.addr);
    end
  end

  always_ff @(posedge link.link_clk) begin
    if (!i_nrst) begin
      s.wr_act <= 1'b0;
      s.wr_w0 <= `QSP_DATA_ZERO;
      s.wr_m0 <= `QSP_MASK_NONE;
      s.rd_pend <= 1'b0;
      s.rd_pend_addr <= `QSP_ADDR_ZERO;
      s.rd_addr <= `QSP_ADDR_ZERO;
      s.rd_st <= QSP_RD_IDLE;
      s.q <= `QSP_DATA_ZERO;
      s.q_oe <= 1'b0;
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  // Both burst words land at K# once the second word is present
  always_ff @(posedge link.link_clk) begin
    if (wr_go) begin
      mem[wr_idx0] <= (mem[wr_idx0] & ~s.wr_m0) | (s.wr_w0 & s.wr_m0);
      mem[wr_idx1] <= (mem[wr_idx1] & ~wr_m1) | (link.d & wr_m1);
    end
  end

  assign link.q = s.q;
  assign link.q_oe = s.q_oe;

endmodule : qsp_sram_dev

// ### qsp_ctrl.sv
// Purpose: Memory controller end driving the burst SRAM link
// Assumes: Link clock is i_clk divided by two; one input clock edge per link cycle
// Notes: Read data returns through a two-flop crossing
`timescale 1ns/10ps
`include "qsp_consts.svh"

module qsp_ctrl
  import qsp_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // Mode
  input wire logic i_single_clk,
  // Read request
  input wire logic i_rd_req,
  input wire qsp_addr_t i_rd_addr,
  output logic o_rd_ready,
  // Write request
  input wire logic i_wr_req,
  input wire qsp_addr_t i_wr_addr,
  input wire qsp_data_t i_wr_data0,
  input wire qsp_data_t i_wr_data1,
  input wire qsp_lane_t i_wr_lanes0_n,
  input wire qsp_lane_t i_wr_lanes1_n,
  output logic o_wr_ready,
  // Read answer
  output qsp_data_t o_rd_data,
  output logic o_rd_valid,
  output logic o_rd_word,
  // Link
  qsp_link_if.ctl link
);

  qsp_ctl_s s;
  qsp_ctl_s next_s;

  always_comb begin
    next_s = s;
    next_s.lclk = ~s.lclk;
    next_s.rd_valid = 1'b0;
    next_s.single = i_single_clk;
    if (i_rd_req && s.rd_ready) begin
      next_s.rd_pend = 1'b1;
      next_s.rd_pa = i_rd_addr;
    end
    if (i_wr_req && s.wr_ready) begin
      next_s.wr_pend = 1'b1;
      next_s.wr_pa = i_wr_addr;
      next_s.wd0 = i_wr_data0;
      next_s.wd1 = i_wr_data1;
      next_s.wl0_n = i_wr_lanes0_n;
      next_s.wl1_n = i_wr_lanes1_n;
    end
    // Pins change on the falling link edge, stable for the next rise
    if (s.lclk) begin
      next_s.kph = ~s.kph;
      if (!s.kph) begin
        next_s.rd_sel_n = ~s.rd_pend;
        // Clear only what is issued, so a request taken this edge survives
        if (s.rd_pend) begin
          next_s.addr = s.rd_pa;
          next_s.rd_pend = 1'b0;
        end
        next_s.wr_sel_n = ~s.wr_pend;
        next_s.d = s.wd0;
        next_s.lanes_n = s.wl0_n;
        next_s.wr_stage = s.wr_pend;
        if (s.wr_pend) begin
          next_s.wr_pend = 1'b0;
        end
      end else begin
        next_s.rd_sel_n = `QSP_SEL_IDLE;
        next_s.wr_sel_n = `QSP_SEL_IDLE;
        if (s.wr_stage) begin
          next_s.addr = s.wr_pa;
          next_s.d = s.wd1;
          next_s.lanes_n = s.wl1_n;
        end
        next_s.wr_stage = 1'b0;
      end
    end
    // Second flop of each synchroniser feeds the capture
    next_s.q_s1 = link.q;
    next_s.q_s2 = s.q_s1;
    next_s.oe_s1 = link.q_oe;
    next_s.oe_s2 = s.oe_s1;
    if (!s.oe_s2) begin
      next_s.widx = `QSP_WORD0;
    end else if (s.lclk) begin
      next_s.rd_data = s.q_s2;
      next_s.rd_valid = 1'b1;
      next_s.rd_word = s.widx;
      next_s.widx = ~s.widx;
    end
    next_s.rd_ready = ~next_s.rd_pend;
    next_s.wr_ready = ~(next_s.wr_pend | next_s.wr_stage);
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      s <= '0;
      s.rd_sel_n <= `QSP_SEL_IDLE;
      s.wr_sel_n <= `QSP_SEL_IDLE;
      s.lanes_n <= ~`QSP_LANES_OFF;
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  // Output clocks follow the input clocks with no added skew
  assign link.link_clk = s.lclk;
  assign link.k_phase = s.kph;
  assign link.c_phase = s.kph;
  assign link.single_clk_mode = s.single;
  assign link.rd_port_sel_n = s.rd_sel_n;
  assign link.wr_port_sel_n = s.wr_sel_n;
  assign link.addr = s.addr;
  assign link.d = s.d;
  assign link.lane_en_n = s.lanes_n;
  assign o_rd_ready = s.rd_ready;
  assign o_wr_ready = s.wr_ready;
  assign o_rd_data = s.rd_data;
  assign o_rd_valid = s.rd_valid;
  assign o_rd_word = s.rd_word;

endmodule : qsp_ctrl

// ### qsp_link_monitor.sv
// Purpose: Link timing checks between controller and SRAM port
// Assumes: Sampled on rising link_clk; i_nrst is the port reset
// Notes: Read launch follows the two-rise pipeline of the port
`timescale 1ns/10ps
`include "qsp_consts.svh"

module qsp_link_monitor
  import qsp_pkg::*;
(
  // Link clock and reset
  input wire logic i_link_clk,
  input wire logic i_nrst,
  // Link signals
  input wire logic i_k_phase,
  input wire logic i_c_phase,
  input wire logic i_rd_port_sel_n,
  input wire logic i_wr_port_sel_n,
  input wire logic i_q_oe
);
  default clocking cb @(posedge i_link_clk);
  endclocking
  default disable iff (!i_nrst);

  property p_rd_at_k;
    !i_rd_port_sel_n |-> i_k_phase;
  endproperty
  a_rd_at_k: assert property (p_rd_at_k) else $error("read select off K edge");
  property p_wr_at_k;
    !i_wr_port_sel_n |-> i_k_phase;
  endproperty
  a_wr_at_k: assert property (p_wr_at_k) else $error("write select off K edge");
  property p_wr_kbar;
    !i_wr_port_sel_n |=> i_wr_port_sel_n && !i_k_phase;
  endproperty
  a_wr_kbar: assert property (p_wr_kbar) else $error("write slot not followed by K#");
  property p_kalt;
    i_k_phase |=> !i_k_phase;
  endproperty
  a_kalt: assert property (p_kalt) else $error("input clock phases not alternating");
  property p_cpair;
    i_c_phase == i_k_phase;
  endproperty
  a_cpair: assert property (p_cpair) else $error("output clock pair misplaced");
  property p_burst;
    (i_k_phase && !i_rd_port_sel_n) |-> ##3 i_q_oe [*2];
  endproperty
  a_burst: assert property (p_burst) else $error("read burst not driven two words");
  property p_oe_start;
    $rose(i_q_oe) |-> $past(i_k_phase && !i_rd_port_sel_n, 3);
  endproperty
  a_oe_start: assert property (p_oe_start) else $error("outputs driven without read");
  property p_oe_stop;
    $fell(i_q_oe) |-> $past(i_c_phase);
  endproperty
  a_oe_stop: assert property (p_oe_stop) else $error("outputs released off C edge");
endmodule : qsp_link_monitor

// ### testbench.sv
// Purpose: Self-checking bench joining controller and SRAM port
// Assumes: x36 organisation; port reset released after controller reset
// Notes: Port reset held longer so the link clock runs during it
`timescale 1ns/10ps
`include "qsp_consts.svh"

module testbench;
  import qsp_pkg::*;
  logic i_clk, nrst, dev_nrst, ce, single, rd_req, wr_req, rd_ready, wr_ready;
  logic rd_valid, rd_word;
  qsp_addr_t rd_addr, wr_addr;
  qsp_data_t wd0, wd1, rd_data;
  qsp_lane_t wl0, wl1;
  qsp_data_t exp_q[$];
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;

  qsp_link_if link ();
  qsp_ctrl qsp_ctrl_inst (.i_clk(i_clk), .i_nrst(nrst), .i_ce(ce), .i_single_clk(single),
    .i_rd_req(rd_req), .i_rd_addr(rd_addr), .o_rd_ready(rd_ready), .i_wr_req(wr_req),
    .i_wr_addr(wr_addr), .i_wr_data0(wd0), .i_wr_data1(wd1), .i_wr_lanes0_n(wl0),
    .i_wr_lanes1_n(wl1), .o_wr_ready(wr_ready), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .o_rd_word(rd_word), .link(link));
  qsp_sram_dev qsp_sram_dev_inst (.link(link), .i_nrst(dev_nrst), .i_ce(ce));
  qsp_link_monitor qsp_link_monitor_inst (.i_link_clk(link.link_clk), .i_nrst(dev_nrst),
    .i_k_phase(link.k_phase), .i_c_phase(link.c_phase),
    .i_rd_port_sel_n(link.rd_port_sel_n), .i_wr_port_sel_n(link.wr_port_sel_n),
    .i_q_oe(link.q_oe));

  // Read bus as the board sees it: floats while the port is not driving
  wire [`QSP_DW-1:0] q_pin;
  assign q_pin = link.q_oe ? link.q : {`QSP_DW{1'bz}};

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic close_out;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // Hang guard, far above the several hundred cycles needed
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      close_out();
    end
  end

  task automatic check(input qsp_data_t seen, input qsp_data_t want);
    tests_run++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic wait_for(ref logic r);
    int n;
    n = 0;
    while (r !== 1'b1 && n < 60) begin
      @(negedge i_clk);
      n++;
    end
    // A ready that never comes is a failure, not a silent skip
    if (r !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: ready never rose", $time);
    end
  endtask : wait_for

  // Waits for ready again so the array holds the data before any read
  task automatic wr(input qsp_addr_t a, input qsp_data_t x0, input qsp_data_t x1,
      input qsp_lane_t l0, input qsp_lane_t l1);
    wait_for(wr_ready);
    wr_req = 1'b1;
    wr_addr = a;
    wd0 = x0;
    wd1 = x1;
    wl0 = l0;
    wl1 = l1;
    @(negedge i_clk);
    wr_req = 1'b0;
    @(negedge i_clk);
    wait_for(wr_ready);
    repeat (4) @(negedge i_clk);
  endtask : wr

  task automatic rd(input qsp_addr_t a, input qsp_data_t x0, input qsp_data_t x1);
    wait_for(rd_ready);
    rd_req = 1'b1;
    rd_addr = a;
    exp_q.push_back(x0);
    exp_q.push_back(x1);
    @(negedge i_clk);
    rd_req = 1'b0;
    @(negedge i_clk);
  endtask : rd

  task automatic collect(input int nw);
    int got;
    got = 0;
    repeat (24 * nw + 24) begin
      @(negedge i_clk);
      if (rd_valid === 1'b1) begin
        check(rd_data, exp_q.pop_front());
        check(qsp_data_t'(rd_word), qsp_data_t'(got % 2));
        got++;
      end
    end
    check(qsp_data_t'(got), qsp_data_t'(nw));
  endtask : collect

  task automatic sc_full;
    wr(21'h00_0123, 36'h1_2345_6789, 36'h9_8765_4321, 4'h0, 4'h0);
    rd(21'h00_0123, 36'h1_2345_6789, 36'h9_8765_4321);
    collect(2);
  endtask : sc_full

  // One lane per pass: word 0 loses it, word 1 keeps only it
  task automatic sc_lanes;
    qsp_data_t m;
    for (int k = 0; k < 4; k++) begin
      m = qsp_data_t'(36'h0_0000_01FF << (9 * k));
      wr(21'h00_0040, 36'hA_AAAA_AAAA, 36'h5_5555_5555, 4'h0, 4'h0);
      wr(21'h00_0040, `QSP_DATA_ZERO, `QSP_DATA_ZERO, ~qsp_lane_t'(4'h1 << k),
        qsp_lane_t'(4'h1 << k));
      rd(21'h00_0040, 36'hA_AAAA_AAAA & ~m, 36'h5_5555_5555 & m);
      collect(2);
    end
  endtask : sc_lanes

  // Top of the 19-bit space, then back-to-back reads
  task automatic sc_bound;
    wr(21'h1F_FFFF, 36'hC_0FFE_E001, 36'h3_1415_9265, 4'h0, 4'h0);
    wr(`QSP_ADDR_ZERO, 36'h0_BEEF_0002, 36'h7_7777_0003, 4'h0, 4'h0);
    rd(21'h07_FFFF, 36'hC_0FFE_E001, 36'h3_1415_9265);
    rd(`QSP_ADDR_ZERO, 36'h0_BEEF_0002, 36'h7_7777_0003);
    collect(4);
  endtask : sc_bound

  task automatic sc_single;
    single = 1'b1;
    wr(21'h00_0777, 36'h8_0000_0001, 36'h0_8000_0010, 4'h0, 4'h0);
    rd(21'h00_0777, 36'h8_0000_0001, 36'h0_8000_0010);
    collect(2);
    single = 1'b0;
  endtask : sc_single

  // Frozen controller must not start a read
  task automatic sc_hold;
    ce = 1'b0;
    rd_req = 1'b1;
    rd_addr = 21'h00_0123;
    repeat (10) @(negedge i_clk);
    rd_req = 1'b0;
    ce = 1'b1;
    collect(0);
    check(q_pin, 36'hz_zzzz_zzzz);
  endtask : sc_hold

  initial begin
    nrst = 1'b0;
    dev_nrst = 1'b0;
    ce = 1'b1;
    single = 1'b0;
    rd_req = 1'b0;
    wr_req = 1'b0;
    rd_addr = `QSP_ADDR_ZERO;
    wr_addr = `QSP_ADDR_ZERO;
    wd0 = `QSP_DATA_ZERO;
    wd1 = `QSP_DATA_ZERO;
    wl0 = 4'hF;
    wl1 = 4'hF;
    repeat (6) @(negedge i_clk);
    nrst = 1'b1;
    repeat (4) @(negedge i_clk);
    dev_nrst = 1'b1;
    repeat (4) @(negedge i_clk);
    sc_full();
    sc_lanes();
    sc_bound();
    sc_single();
    sc_hold();
    close_out();
  end
endmodule : testbench
